// [src/microport_pkg.sv]
package microport_pkg;
   localparam int        DATA_W        = 8;
   localparam int        ADDR_W        = 3;
   localparam int        CLK_PERIOD_NS = 100;
   // longest access time from strobe fall to ready, in device clock periods
   localparam int        ACC_MAX_CLKS  = 9;
   // cycles the core is given to answer; kept well under the limit above
   localparam int        ACC_CLKS      = 4;
   localparam logic [7:0] RDATA_RST    = 8'h00;
   localparam logic [2:0] ADDR_RST     = 3'h0;
   // idle pin levels for the synchronisers: deselected, both strobes high, mode 0
   localparam logic [14:0] PINS_RST    = 15'h000E;
endpackage

// [src/dual_mode_microport_pins.sv]
`timescale 1ns/1ps
// What this block does
// - the data bus is released whenever chip select is high and driven only while it is low.
// - the mode pin picks separate read/write strobes at 0 and data strobe with direction at 1.
// - in mode 1 the device pulls the data acknowledge low when the access has completed.
// - in mode 0 the acknowledge pin is a ready status telling the host the access may finish.
// - in mode 0 ready rises within 9 device clocks of the write strobe falling.
module dual_mode_microport_pins (
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       clk_en_i,
   input  wire logic       host_cs_n_i,
   input  wire logic [2:0] host_addr_i,
   input  wire logic       host_data_strobe_n_i,
   input  wire logic       host_rw_i,
   input  wire logic       strobe_dir_mode_i,
   input  wire logic [7:0] host_data_i,
   output logic      [7:0] host_data_o,
   output logic            host_data_oe_o,
   output logic            host_access_ack_n_o,
   output logic            host_access_ack_oe_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [2:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} acc_state_t;

   // two-flop synchronisers for every host pin; stage one feeds stage two only
   logic [14:0] sync1_reg;
   logic [14:0] sync2_reg;
   wire  [14:0] pins_raw = {host_data_i, host_addr_i, host_cs_n_i,
                            host_data_strobe_n_i, host_rw_i, strobe_dir_mode_i};
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_reg <= microport_pkg::PINS_RST;
         sync2_reg <= microport_pkg::PINS_RST;
      end else if (clk_en_i) begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
      end
   end

   wire [7:0] wdata_s = sync2_reg[14:7];
   wire [2:0] addr_s  = sync2_reg[6:4];
   wire       cs_n_s  = sync2_reg[3];
   wire       ds_n_s  = sync2_reg[2];
   wire       rw_s    = sync2_reg[1];
   wire       mode_s  = sync2_reg[0];

   // the mode pin level is the mode number
   wire mode1     = mode_s;
   wire sel       = !cs_n_s;
   // mode 1: data strobe low, rw high = read
   wire m1_rd     = mode1 && sel && !ds_n_s && rw_s;
   wire m1_wr     = mode1 && sel && !ds_n_s && !rw_s;
   // mode 0: shared strobe pin is read strobe, direction pin is write strobe
   wire m0_rd     = !mode1 && sel && !ds_n_s;
   wire m0_wr     = !mode1 && sel && !rw_s && ds_n_s;
   wire rd_active = m1_rd || m0_rd;
   wire wr_active = m1_wr || m0_wr;
   wire acc_req   = rd_active || wr_active;

   acc_state_t state_reg;
   acc_state_t state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] rdata_reg;
   logic [2:0] addr_reg;
   logic [7:0] wdata_reg;
   logic       wr_pulse_reg;
   logic       rd_pulse_reg;
   logic       is_rd_reg;

   wire start    = (state_reg == ST_IDLE) && acc_req;
   wire cnt_done = (cnt_reg == 4'(microport_pkg::ACC_CLKS - 1));

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = 4'h0;
            if (acc_req) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            cnt_next = cnt_reg + 4'h1;
            if (!acc_req) begin
               state_next = ST_IDLE;
            end else if (cnt_done) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            if (!acc_req) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg    <= ST_IDLE;
         cnt_reg      <= 4'h0;
         rdata_reg    <= microport_pkg::RDATA_RST;
         addr_reg     <= microport_pkg::ADDR_RST;
         wdata_reg    <= microport_pkg::RDATA_RST;
         wr_pulse_reg <= 1'b0;
         rd_pulse_reg <= 1'b0;
         is_rd_reg    <= 1'b0;
      end else if (clk_en_i) begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         wr_pulse_reg <= start && wr_active;
         rd_pulse_reg <= start && rd_active;
         if (start) begin
            addr_reg  <= addr_s;
            wdata_reg <= wdata_s;
            is_rd_reg <= rd_active;
         end
         // read data captured from the core while waiting, held until ack
         if (state_reg == ST_WAIT && is_rd_reg) begin
            rdata_reg <= reg_rdata_i;
         end
      end
   end

   assign reg_addr_o  = addr_reg;
   assign reg_wdata_o = wdata_reg;
   assign reg_wr_o    = wr_pulse_reg;
   assign reg_rd_o    = rd_pulse_reg;

   // the raw select pin gates both enables, so a deselect frees the pins at once
   // instead of two clocks later; it can only switch an enable off, never on
   assign host_data_o    = rdata_reg;
   assign host_data_oe_o = !host_cs_n_i && sel && rd_active && is_rd_reg
                           && (state_reg != ST_IDLE);

   wire done = (state_reg == ST_DONE);
   // mode 1: acknowledge low on completion until the strobe goes; mode 0: ready high
   assign host_access_ack_n_o  = mode1 ? !(done && acc_req) : (done || !acc_req);
   assign host_access_ack_oe_o = !host_cs_n_i && sel;

   property p_bus_release;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (cs_n_s || host_cs_n_i) |-> !host_data_oe_o;
   endproperty
   a_bus_release: assert property (p_bus_release) else $error("bus driven while deselected");

   property p_read_qual;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         host_data_oe_o |-> (sel && rd_active);
   endproperty
   a_read_qual: assert property (p_read_qual) else $error("bus driven without read");

   sequence s_m0_wr_start;
      clk_en_i && start && m0_wr;
   endsequence
   property p_m0_ready_time;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         s_m0_wr_start ##1 (m0_wr && clk_en_i)[*4] |=> host_access_ack_n_o;
   endproperty
   a_m0_ready_time: assert property (p_m0_ready_time) else $error("ready late");

   property p_m0_not_early;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (clk_en_i && start && m0_wr) |=> !host_access_ack_n_o;
   endproperty
   a_m0_not_early: assert property (p_m0_not_early) else $error("ready early");

   property p_m1_ack;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (mode1 && !host_access_ack_n_o) |-> (done && acc_req);
   endproperty
   a_m1_ack: assert property (p_m1_ack) else $error("ack without completion");

   sequence s_m1_wr_start;
      clk_en_i && start && m1_wr;
   endsequence
   property p_m1_ack_time;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         s_m1_wr_start ##1 (m1_wr && clk_en_i)[*4] |=> !host_access_ack_n_o;
   endproperty
   a_m1_ack_time: assert property (p_m1_ack_time) else $error("ack late");

   property p_addr_cap;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (clk_en_i && start) |=> (reg_addr_o == $past(addr_s));
   endproperty
   a_addr_cap: assert property (p_addr_cap) else $error("address not captured");

   property p_one_write;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         reg_wr_o |=> !reg_wr_o;
   endproperty
   a_one_write: assert property (p_one_write) else $error("write repeated");

   property p_wr_pulse;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (clk_en_i && start && wr_active) |=> (reg_wr_o && !reg_rd_o);
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write not passed on");

   property p_rd_pulse;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (clk_en_i && start && rd_active) |=> (reg_rd_o && !reg_wr_o);
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read not passed on");

   // once acknowledged, read data must not move while the host still reads it
   property p_rdata_hold;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         (clk_en_i && done && is_rd_reg && acc_req) |=> $stable(host_data_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   sequence s_m1_acked;
      mode1 && done && acc_req;
   endsequence
   property p_m1_ack_release;
      @(posedge ref_clk_i) disable iff (!nrst_i)
         s_m1_acked ##1 !acc_req |-> host_access_ack_n_o;
   endproperty
   a_m1_ack_release: assert property (p_m1_ack_release) else $error("ack stuck");
endmodule

// [tb/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model (
   input  wire logic       ref_clk_i,
   output logic            cs_n_o,
   output logic      [2:0] addr_o,
   output logic            strobe_n_o,
   output logic            rw_o,
   output logic            mode_o,
   output logic      [7:0] bus_o,
   input  wire logic [7:0] dev_data_i,
   input  wire logic       dev_oe_i,
   input  wire logic       ack_n_i
);
   logic       drv = 1'b0;
   logic [7:0] wd  = 8'h00;
   // a released bus shows the inverse of the last written byte, never a stale copy
   assign bus_o = dev_oe_i ? dev_data_i : (drv ? wd : ~wd);
   initial begin
      {cs_n_o, strobe_n_o, rw_o, mode_o, addr_o} = 7'h78;
   end
   task automatic access(input logic m, input logic wr, input logic [2:0] a,
                         input logic [7:0] d, output logic [7:0] q, output int n);
      logic seen;
      seen = 1'b0;
      n = 0;
      @(posedge ref_clk_i);
      #1;
      mode_o = m;
      repeat (3) @(posedge ref_clk_i);
      #1;
      cs_n_o = 1'b0;
      addr_o = a;
      if (wr) wd = d;
      drv = wr;
      if (m) begin
         rw_o = ~wr;
         strobe_n_o = 1'b0;
      end else if (wr) begin
         rw_o = 1'b0;
      end else begin
         strobe_n_o = 1'b0;
      end
      // mode 0 ready is high when idle, so the low phase must be seen first
      do begin
         @(posedge ref_clk_i);
         n++;
         if (ack_n_i === 1'b0) seen = 1'b1;
      end while (n < 20 && !(m ? seen : (seen && ack_n_i === 1'b1)));
      q = bus_o;
      #1;
      {cs_n_o, strobe_n_o, rw_o, drv} = 4'hE;
      repeat (3) @(posedge ref_clk_i);
   endtask
endmodule

// [tb/tb_dual_mode_microport_pins.sv]
`timescale 1ns/1ps
module tb_dual_mode_microport_pins;
   logic       ref_clk_i, nrst_i, clk_en_i, host_cs_n_i, host_data_strobe_n_i, host_rw_i;
   logic       strobe_dir_mode_i, host_data_oe_o, host_access_ack_n_o, host_access_ack_oe_o;
   logic       reg_wr_o, reg_rd_o;
   logic [2:0] host_addr_i, reg_addr_o, cap_addr;
   logic [7:0] host_data_i, host_data_o, reg_wdata_o, reg_rdata_i, cap_data;
   int         fails, n_tests, wr_cnt, rd_cnt;
   wire logic  ack_pin = host_access_ack_oe_o ? host_access_ack_n_o : 1'b1;
   dual_mode_microport_pins i_dual_mode_microport_pins (
      .ref_clk_i            (ref_clk_i),
      .nrst_i               (nrst_i),
      .clk_en_i             (clk_en_i),
      .host_cs_n_i          (host_cs_n_i),
      .host_addr_i          (host_addr_i),
      .host_data_strobe_n_i (host_data_strobe_n_i),
      .host_rw_i            (host_rw_i),
      .strobe_dir_mode_i    (strobe_dir_mode_i),
      .host_data_i          (host_data_i),
      .host_data_o          (host_data_o),
      .host_data_oe_o       (host_data_oe_o),
      .host_access_ack_n_o  (host_access_ack_n_o),
      .host_access_ack_oe_o (host_access_ack_oe_o),
      .reg_wr_o             (reg_wr_o),
      .reg_rd_o             (reg_rd_o),
      .reg_addr_o           (reg_addr_o),
      .reg_wdata_o          (reg_wdata_o),
      .reg_rdata_i          (reg_rdata_i)
   );
   host_bus_model i_host_bus_model (.ref_clk_i(ref_clk_i), .cs_n_o(host_cs_n_i),
      .addr_o(host_addr_i), .strobe_n_o(host_data_strobe_n_i), .rw_o(host_rw_i),
      .mode_o(strobe_dir_mode_i), .bus_o(host_data_i), .dev_data_i(host_data_o),
      .dev_oe_i(host_data_oe_o), .ack_n_i(ack_pin));
   always @(posedge ref_clk_i) begin
      if (reg_wr_o === 1'b1) begin
         wr_cnt++;
         cap_addr <= reg_addr_o;
         cap_data <= reg_wdata_o;
      end
      if (reg_rd_o === 1'b1) begin
         rd_cnt++;
         cap_addr <= reg_addr_o;
      end
   end
   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         fails++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask
   task automatic xfer(input logic m, input logic wr, input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      int         n;
      int         w0;
      int         r0;
      @(posedge ref_clk_i);
      #1;
      w0 = wr_cnt;
      r0 = rd_cnt;
      reg_rdata_i = ~d;
      i_host_bus_model.access(m, wr, a, d, q, n);
      check(n >= 1 && n <= microport_pkg::ACC_MAX_CLKS, "ready late");
      check(wr_cnt - w0 == (wr ? 1 : 0) && rd_cnt - r0 == (wr ? 0 : 1), "pulses");
      check(cap_addr === a, "address");
      if (wr) check(cap_data === d, "write data");
      else check(q === ~d, "read data");
      check(host_data_oe_o === 1'b0, "bus held");
   endtask
   task automatic m1_write();
      xfer(1'b1, 1'b1, 3'h7, 8'hA5);
      $display("m1_write done");
   endtask
   task automatic m1_read();
      xfer(1'b1, 1'b0, 3'h0, 8'h3C);
      $display("m1_read done");
   endtask
   task automatic m0_write();
      xfer(1'b0, 1'b1, 3'h5, 8'hFF);
      $display("m0_write done");
   endtask
   task automatic m0_read();
      xfer(1'b0, 1'b0, 3'h2, 8'h00);
      $display("m0_read done");
   endtask
   // with the clock enable low the port must neither answer nor pass a write on
   task automatic freeze();
      logic [7:0] q;
      int         n;
      int         w0;
      @(posedge ref_clk_i);
      #1;
      w0 = wr_cnt;
      clk_en_i = 1'b0;
      i_host_bus_model.access(1'b1, 1'b1, 3'h1, 8'h5A, q, n);
      check(n > microport_pkg::ACC_MAX_CLKS && wr_cnt == w0, "frozen port answered");
      #1;
      clk_en_i = 1'b1;
      $display("freeze done");
   endtask
   task automatic reset_mid();
      @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b0;
      #1;
      check(host_data_o === microport_pkg::RDATA_RST, "read data in reset");
      check(reg_addr_o === microport_pkg::ADDR_RST && reg_wr_o === 1'b0, "core in reset");
      repeat (3) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      xfer(1'b1, 1'b0, 3'h6, 8'h96);
      $display("reset_mid done");
   endtask
   task automatic tally_and_finish();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #(microport_pkg::CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #200000;
      fails++;
      $display("ERROR at %0t: watchdog", $time);
      tally_and_finish();
   end
   initial begin
      {nrst_i, clk_en_i, reg_rdata_i, fails, n_tests} = '0;
      clk_en_i = 1'b1;
      repeat (12) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      m1_write();
      m1_read();
      m0_write();
      m0_read();
      freeze();
      reset_mid();
      tally_and_finish();
   end
endmodule
